// File: hw/adsp_clip.sv
// Saturating formatter: raw signed code to left-justified 16-bit result word
module adsp_clip
	import adsp_pkg::*;
#(
	parameter int RAW_W = 16
)
(
	// Raw code from the modulator back end
	input  wire logic signed [RAW_W-1:0] raw_in,
	// Formatted word
	output logic             [15:0]      word_out
);

	localparam logic signed [RAW_W-1:0] POS_LIM = RAW_W'(CODE_POS_FS);  // Upper clip
	localparam logic signed [RAW_W-1:0] NEG_LIM = RAW_W'(CODE_NEG_FS);  // Lower clip

	if (RAW_W < CODE_BITS)
	begin : g_bad_raw
		$error("adsp_clip: RAW_W narrower than the result");
	end

	// Clip at full scale, else keep the low code bits and pad below
	always_comb
	begin
		if (raw_in > POS_LIM)
			word_out = CODE_MAX;  // [RL2]
		else if (raw_in < NEG_LIM)
			word_out = CODE_MIN;  // [RL2]
		else
			word_out = {raw_in[CODE_BITS-1:0], PAD_BITS};  // [RL1] [RL17]
	end

endmodule // adsp_clip

// File: hw/adsp_pkg.sv
// Shared constants, field layouts and carrier types of the converter serial port
package adsp_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;          // System clock period
	localparam int TIMEOUT_NS      = 30_800_000;  // Serial clock low time-out, 30.8 ms
	localparam int TIMEOUT_CYCLES  = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READY_LEAD_NS   = 8_000;       // Ready withdrawn 8 us before next result
	localparam int READY_LEAD_CYC  = READY_LEAD_NS / CLK_PERIOD_NS;
	localparam int CONV_CYCLES_DEF = 62_500;      // Plain default conversion length

	// ------------------------------------------------------------
	// Register values and fields
	// ------------------------------------------------------------
	localparam logic [15:0] RESULT_RESET = 16'h0000;  // Result after power-up
	localparam logic [15:0] CFG_RESET    = 16'h058B;  // Settings after power-up
	localparam logic [15:0] CODE_MAX     = 16'h7FF0;  // Positive full-scale word
	localparam logic [15:0] CODE_MIN     = 16'h8000;  // Negative full-scale word
	localparam int          CODE_BITS    = 12;        // Result resolution
	localparam int          CODE_POS_FS  = 2047;      // Largest 12-bit code
	localparam int          CODE_NEG_FS  = -2048;     // Smallest 12-bit code
	localparam logic [3:0]  PAD_BITS     = 4'h0;      // Reserved low result bits
	localparam logic [1:0]  WV_VALID     = 2'h1;      // Write-valid code that updates
	localparam int          CFG_START    = 15;        // Single-shot start bit
	localparam int          CFG_WV_HI    = 2;         // Write-valid field top
	localparam int          CFG_WV_LO    = 1;         // Write-valid field bottom
	localparam logic [5:0]  XFER_HALF    = 6'h10;     // Bits in one half transfer
	localparam logic [5:0]  XFER_FULL    = 6'h20;     // Bits in a full transfer

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic cs_n;   // Chip select, active low
		logic sclk;   // Serial clock from master
		logic din;    // Serial data in
	} adsp_pins_in_type;

	typedef struct packed {
		logic serial_out_ready_n;     // Data out / ready level
		logic serial_out_ready_n_oe;  // Drive enable of that pin
		logic weak_pullup_on;         // Weak pullup switched on
	} adsp_pins_out_type;

	typedef struct packed {
		logic       start;               // Single-shot start, reads zero
		logic [2:0] mux_sel;             // Input selection
		logic [2:0] gain_range;          // Full-scale range
		logic       mode;                // 1 single-shot, 0 continuous
		logic [2:0] sample_rate;         // Data rate
		logic       temp_sensor_select;  // Temperature conversion
		logic       weak_pullup_enable;  // Pullup while deselected
		logic [1:0] write_valid;         // Write qualifier
		logic       fixed_one;           // Read-only one
	} adsp_settings_type;

endpackage : adsp_pkg

// File: hw/adsp_port.sv
// Serial data and settings port of the converter, with conversion sequencing
//
// Contract
// [RL1] Result is 12-bit twos complement, left-justified
// [RL2] Clip words at 7FF0h and 8000h
// [RL3] Mode 0 converts back to back always
// [RL4] Mode 1 converts only on start write
// [RL5] Result buffered until newer result replaces it
// [RL6] Bit 15 leaves on first rising edge
// [RL7] Settings captured on falling edges meanwhile
// [RL8] Transfer is 32 or 16 bits
// [RL9] 32-bit: result then settings readback, MSB first
// [RL10] Readback equals settings written this transfer
// [RL11] Master repeats settings or holds input steady
// [RL12] Master holds input steady when not writing
// [RL13] Fast master pauses 16 us between halves
// [RL14] Master raises select after 16-bit transfer
// [RL15] Next select fall sends buffered result
// [RL16] Result reads zero until first conversion
// [RL17] Result low four bits read zero
// [RL18] Settings reset 058Bh with fixed layout
// [RL19] Start launches only while powered down
// [RL20] Start bit always reads back zero
// [RL21] Ready pin low signals fresh result
// [RL22] Settings update only when write-valid is 01
// [RL23] Select high resets and releases pin
// [RL24] Serial clock low 30.8 ms resets port
// [RL25] Unread continuous result: ready high 8 us early
// [RL26] Ready stays off after transfer starts
module adsp_port
	import adsp_pkg::*;
#(
	parameter int RAW_W          = 16,
	parameter int CONV_CYCLES    = CONV_CYCLES_DEF,
	parameter int TIMEOUT_CYC    = TIMEOUT_CYCLES
)
(
	// Clock and control
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_in,
	input  wire logic                      ce_in,
	// Serial pins
	input  wire adsp_pkg::adsp_pins_in_type  pins_in,
	output adsp_pkg::adsp_pins_out_type      pins_out,
	// Modulator back end
	input  wire logic signed [RAW_W-1:0]   raw_code_in,
	output logic                           converting_out,
	// Settings seen by the front end
	output adsp_pkg::adsp_settings_type      settings_out
);
	import adsp_pkg::*;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (CONV_CYCLES <= READY_LEAD_CYC + 1)
	begin : g_bad_conv
		$error("adsp_port: CONV_CYCLES must exceed the ready lead");
	end
	if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << 22))
	begin : g_bad_tmo
		$error("adsp_port: TIMEOUT_CYC out of range");
	end
	if (CONV_CYCLES >= (1 << 20))
	begin : g_bad_conv_w
		$error("adsp_port: CONV_CYCLES too large for the timer");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum logic {ADSP_IDLE, ADSP_CONV} adsp_state_type;

	localparam logic [19:0] CONV_LAST = 20'(CONV_CYCLES - 1);   // Timer load
	localparam logic [19:0] LEAD_AT   = 20'(READY_LEAD_CYC);    // Ready withdraw point
	localparam logic [21:0] TMO_LAST  = 22'(TIMEOUT_CYC - 1);   // Time-out point

	adsp_pins_in_type  pins_s;          // Synchronised pins
	logic [2:0]        sync_q;          // Synchroniser output, select inverted
	logic              sclk_prev_q;     // Previous serial clock level
	logic              sclk_rise;       // Serial clock rising edge
	logic              sclk_fall;       // Serial clock falling edge
	logic [5:0]        bit_cnt_q, bit_cnt_d;      // Rising edges in transfer
	logic [15:0]       tx_q, tx_d;                // Outgoing shift word
	logic [15:0]       rx_q, rx_d;                // Incoming shift word
	logic [21:0]       tmo_q, tmo_d;              // Serial clock low timer
	logic [15:0]       result_q, result_d;        // Buffered result
	logic [15:0]       clipped;                   // Formatted new result
	adsp_settings_type cfg_q, cfg_d;              // Settings register
	logic              ready_q, ready_d;          // Fresh result pending
	adsp_state_type    state_q, state_d;          // Conversion sequencer
	logic [19:0]       timer_q, timer_d;          // Conversion timer
	logic              shot_req;                  // Start written this cycle
	logic              conv_done;                 // Conversion finishing now
	logic [15:0]       word_in;                   // Completed incoming word
	adsp_pins_out_type pins_d;                    // Next pin values

	// ------------------------------------------------------------
	// Pin synchronisation and formatting
	// ------------------------------------------------------------
	adsp_sync #(.WIDTH(3)) u_sync
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.d_in       (pins_in ^ 3'h4),
		.q_out      (sync_q)
	);

	adsp_clip #(.RAW_W(RAW_W)) u_clip
	(
		.raw_in   (raw_code_in),
		.word_out (clipped)
	);

	// Select travels inverted, so the zeroed synchroniser reads deselected after reset
	assign pins_s    = sync_q ^ 3'h4;  // [RL23]
	// Edges only count while selected; a deselected port ignores the clock
	assign sclk_rise = pins_s.sclk & ~sclk_prev_q & ~pins_s.cs_n;  // [RL23]
	assign sclk_fall = ~pins_s.sclk & sclk_prev_q & ~pins_s.cs_n;  // [RL23]
	assign word_in   = {rx_q[14:0], pins_s.din};
	assign conv_done = (state_q == ADSP_CONV) && (timer_q == '0);

	// ------------------------------------------------------------
	// Serial shifter and settings register
	// ------------------------------------------------------------
	// Next values of the shifter, time-out and settings
	always_comb
	begin
		bit_cnt_d = bit_cnt_q;
		tx_d      = tx_q;
		rx_d      = rx_q;
		cfg_d     = cfg_q;
		shot_req  = 1'b0;
		tmo_d     = (pins_s.sclk || bit_cnt_q == '0) ? '0 : tmo_q + 22'h000001;
		if (sclk_rise)
		begin
			bit_cnt_d = bit_cnt_q + 6'h01;
			if (bit_cnt_q == '0)
				tx_d = result_q;  // Lock the result for the whole transfer [RL6] [RL15]
			else if (bit_cnt_q == XFER_HALF)
				tx_d = cfg_q;     // Readback after the result bytes [RL9] [RL10]
			else
				tx_d = {tx_q[14:0], 1'b0};  // MSB first [RL6] [RL9]
		end
		if (sclk_fall)
		begin
			rx_d = word_in;  // [RL7]
			if (bit_cnt_q == XFER_HALF && word_in[CFG_WV_HI:CFG_WV_LO] == WV_VALID)
			begin
				// Start and bit 0 are not storable [RL22] [RL20] [RL18]
				cfg_d = {1'b0, word_in[14:1], 1'b1};
				shot_req = word_in[CFG_START];
			end
			if (bit_cnt_q == XFER_FULL)
				bit_cnt_d = '0;  // Full transfer done, next clock starts anew [RL8]
		end
		// Stalled clock or deselect resets the interface
		if (tmo_q == TMO_LAST || pins_s.cs_n)
		begin
			bit_cnt_d = '0;  // [RL24] [RL23]
			tmo_d     = '0;
		end
	end

	// Register the shifter group
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			sclk_prev_q <= 1'b0;
			bit_cnt_q   <= '0;
			tx_q        <= '0;
			rx_q        <= '0;
			tmo_q       <= '0;
			cfg_q       <= CFG_RESET;  // [RL18]
		end
		else if (ce_in)
		begin
			sclk_prev_q <= pins_s.sclk;
			bit_cnt_q   <= bit_cnt_d;
			tx_q        <= tx_d;
			rx_q        <= rx_d;
			tmo_q       <= tmo_d;
			cfg_q       <= cfg_d;
		end
	end

	// ------------------------------------------------------------
	// Conversion sequencer, result buffer and ready flag
	// ------------------------------------------------------------
	// Next values of the sequencer; a new result always beats a clear
	always_comb
	begin
		state_d  = state_q;
		timer_d  = timer_q;
		result_d = result_q;
		ready_d  = ready_q;
		if (sclk_rise && bit_cnt_q == '0)
			ready_d = 1'b0;  // Transfer started [RL26]
		case (state_q)
			ADSP_IDLE:
			begin
				// Powered down until mode 0 or a start write [RL3] [RL4] [RL19]
				if (!cfg_q.mode || (shot_req && cfg_d.mode))
				begin
					state_d = ADSP_CONV;
					timer_d = CONV_LAST;
				end
			end
			ADSP_CONV:
			begin
				if (timer_q == LEAD_AT && !cfg_q.mode)
					ready_d = 1'b0;  // Unread result withdrawn early [RL25]
				if (conv_done)
				begin
					result_d = clipped;  // Replaced only by a newer one [RL5]
					ready_d  = 1'b1;     // [RL21]
					timer_d  = CONV_LAST;
					if (cfg_q.mode)
						state_d = ADSP_IDLE;  // Single shot powers down again
				end
				else
					timer_d = timer_q - 20'h00001;  // Start writes ignored here [RL19]
			end
			default:
				state_d = ADSP_IDLE;
		endcase
	end

	// Register the sequencer group
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			state_q  <= ADSP_IDLE;
			timer_q  <= '0;
			result_q <= RESULT_RESET;  // [RL16]
			ready_q  <= 1'b0;
		end
		else if (ce_in)
		begin
			state_q  <= state_d;
			timer_q  <= timer_d;
			result_q <= result_d;
			ready_q  <= ready_d;
		end
	end

	// ------------------------------------------------------------
	// Pin drive and outputs
	// ------------------------------------------------------------
	// Shift data during a transfer, ready level between transfers
	always_comb
	begin
		pins_d.serial_out_ready_n_oe = ~pins_s.cs_n;  // Released while deselected [RL23]
		pins_d.weak_pullup_on        = pins_s.cs_n & cfg_q.weak_pullup_enable;
		if (bit_cnt_d != '0)
			pins_d.serial_out_ready_n = tx_d[15];  // [RL6]
		else
			pins_d.serial_out_ready_n = ~ready_d;  // [RL21]
	end

	// All outputs straight from flip-flops
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			pins_out       <= '{serial_out_ready_n: 1'b1, default: 1'b0};
			converting_out <= 1'b0;
			settings_out   <= CFG_RESET;
		end
		else if (ce_in)
		begin
			pins_out       <= pins_d;
			converting_out <= (state_d == ADSP_CONV);
			settings_out   <= cfg_d;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_pad_zero;
		@(posedge sys_clk_in) disable iff (rst_in)
		result_q[3:0] == PAD_BITS;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("result pad bits not zero"); // [RL17]

	property p_clip_high;
		@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && conv_done && raw_code_in > RAW_W'(CODE_POS_FS) |=> result_q == CODE_MAX;
	endproperty
	a_clip_high: assert property (p_clip_high) else $error("positive clip wrong"); // [RL2]

	property p_cont_runs;
		@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && state_q == ADSP_IDLE && !cfg_q.mode |=> state_q == ADSP_CONV;
	endproperty
	a_cont_runs: assert property (p_cont_runs) else $error("continuous mode idle"); // [RL3]

	property p_single_waits;
		@(posedge sys_clk_in) disable iff (rst_in)
		state_q == ADSP_IDLE && cfg_q.mode && !shot_req |=> state_q == ADSP_IDLE;
	endproperty
	a_single_waits: assert property (p_single_waits) else $error("spontaneous shot"); // [RL4]

	property p_start_reads_zero;
		@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && sclk_rise && bit_cnt_q == XFER_HALF |=> !tx_q[15] && tx_q[0];
	endproperty
	a_start_reads_zero: assert property (p_start_reads_zero) else $error("readback bits wrong"); // [RL20]

	property p_nop_keeps;
		@(posedge sys_clk_in) disable iff (rst_in)
		sclk_fall && word_in[CFG_WV_HI:CFG_WV_LO] != WV_VALID |=> $stable(cfg_q);
	endproperty
	a_nop_keeps: assert property (p_nop_keeps) else $error("settings changed on no-op"); // [RL22]

	property p_deselect;
		@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && pins_s.cs_n |=> bit_cnt_q == '0 && !pins_out.serial_out_ready_n_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect did not reset"); // [RL23]

	property p_ready_off;
		@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && sclk_rise && bit_cnt_q == '0 && !conv_done |=> !ready_q;
	endproperty
	a_ready_off: assert property (p_ready_off) else $error("ready kept after start"); // [RL26]

	property p_msb_first;
		@(posedge sys_clk_in) disable iff (rst_in)
		ce_in && sclk_rise && bit_cnt_q == '0 ##1 ce_in |=> pins_out.serial_out_ready_n == $past(result_q[15], 2);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit not result MSB"); // [RL6]

endmodule // adsp_port

// File: hw/adsp_sync.sv
// Two-stage synchroniser for pin inputs, with clock enable
module adsp_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and control
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	// Data
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

	if (WIDTH < 1)
	begin : g_bad_width
		$error("adsp_sync: WIDTH must be at least 1");
	end

	// Both stages reset to idle-low; the first is read only by the second
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			meta_q <= '0;
			q_out  <= '0;
		end
		else if (ce_in)
		begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule // adsp_sync

// File: test/adsp_spi_master.sv
// Serial master model that reads results and writes settings through the port
module adsp_spi_master
(
	// Clock and returned data
	input  wire logic                   sys_clk_in,
	input  wire logic                   dout_in,
	// Serial pins toward the port
	output adsp_pkg::adsp_pins_in_type  pins_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import adsp_pkg::*;

	// ------------------------------------------------------------
	// Link timing
	// ------------------------------------------------------------
	localparam int HALF  = 8;     // Sys cycles per serial clock phase, 80 ns
	localparam int PAUSE = 1400;  // Gap so bit 1 to bit 17 rises span over 16 us

	// Idle: deselected, serial clock low
	initial pins_out = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

	// Wait n rising edges; every pin change follows such an edge
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	// One transfer, tx sent MSB first; rx holds the bits seen before each fall
	task automatic xfer(input logic [31:0] tx, input int nbits, input logic raise,
		output logic rdy_n, output logic [31:0] rx);
		rx = 32'h0;
		// Select only if not already selected (held-low use)
		if (pins_out.cs_n)
		begin
			pins_out.cs_n <= 1'b0;
			wait_clk(HALF);
		end
		rdy_n = dout_in;
		for (int i = 0; i < nbits; i++)
		begin
			// Fast clock: pause between halves for settings decode
			if (i == 16)
				wait_clk(PAUSE);
			pins_out.sclk <= 1'b1;
			pins_out.din  <= tx[31-i];
			wait_clk(HALF);
			rx[31-i] = dout_in;
			pins_out.sclk <= 1'b0;
			wait_clk(HALF);
		end
		// Transfers end by deselecting when raise is set, at any length
		if (raise)
		begin
			pins_out.cs_n <= 1'b1;
			wait_clk(HALF);
		end
	endtask

endmodule // adsp_spi_master

// File: test/testbench.sv
// Self-checking bench of the converter serial port
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import adsp_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int CONV = 1000;  // Shortened conversion length
	localparam int TOUT = 4000;  // Shortened time-out, kept above the half pause
	logic               sys_clk;
	logic               rst;
	logic               ce;
	logic               last_lvl;  // Last wire level, for the floating case
	logic               dout;      // Resolved data/ready wire
	logic               rdy_n;
	logic               converting;
	logic signed [15:0] raw;
	logic [31:0]        rx;
	logic [15:0]        cfg;       // Expected settings
	logic [15:0]        res;       // Expected result
	logic [1:0]         wv;
	int                 failures;
	int                 n_tests;
	int                 k;
	int                 vals[6] = '{3000, 2047, 1, -1, -2048, -5000};
	adsp_pins_in_type   pins;
	adsp_pins_out_type  pout;
	adsp_settings_type  settings;

`define CHK(got, exp) \
	begin n_tests++; if ((got) !== (exp)) begin failures++; \
	$display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

	// ------------------------------------------------------------
	// Clock, wire and instances
	// ------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Undriven without pullup: show a toggling level, never a stale one
	assign dout = pout.serial_out_ready_n_oe ? pout.serial_out_ready_n
		: (pout.weak_pullup_on ? 1'b1 : ~last_lvl);
	always @(posedge sys_clk)
		last_lvl <= dout;

	adsp_port #(.RAW_W(16), .CONV_CYCLES(CONV), .TIMEOUT_CYC(TOUT)) dut (
		.sys_clk_in(sys_clk), .rst_in(rst), .ce_in(ce), .pins_in(pins),
		.pins_out(pout), .raw_code_in(raw), .converting_out(converting),
		.settings_out(settings));

	adsp_spi_master host (.sys_clk_in(sys_clk), .dout_in(dout), .pins_out(pins));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clipped, left-justified word for a raw code
	function automatic logic [15:0] exp_word(input int v);
		if (v > 2047)
			return 16'h7FF0;
		if (v < -2048)
			return 16'h8000;
		return {v[11:0], 4'h0};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Bounded wait for the running conversion to end; n is cycles waited
	task automatic wait_done(output int n);
		n = 0;
		while (converting !== 1'b0 && n < 3 * CONV)
		begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(converting, 1'b0);
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial
	begin
		#600_000;
		failures++;
		conclude();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		raw = 16'sh0;
		last_lvl = 1'b0;
		failures = 0;
		n_tests = 0;
		res = 16'h0000;
		cyc(20);
		rst <= 1'b0;
		cyc(6);
		// Power-up state, deselected
		`CHK(settings, CFG_RESET);
		`CHK(pout.weak_pullup_on, 1'b1);
		`CHK(pout.serial_out_ready_n_oe, 1'b0);
		// Steady zeros then steady ones: nothing written, nothing ready
		for (int i = 0; i < 2; i++)
		begin
			host.xfer({32{i[0]}}, 32, 1'b1, rdy_n, rx);
			`CHK(rdy_n, 1'b1);
			`CHK(rx, {16'h0000, 16'h058B});
			`CHK(settings, CFG_RESET);
		end
		// Single shots over the clip table; each write reads the prior result
		foreach (vals[i])
		begin
			raw <= vals[i][15:0];
			host.xfer({16'h858B, 16'h0}, 16, 1'b1, rdy_n, rx);
			`CHK(rdy_n, (i == 0) ? 1'b1 : 1'b0);
			`CHK(rx[31:16], res);
			`CHK(converting, 1'b1);
			// A start during a conversion must not restart it
			if (i == 0)
				host.xfer({16'h858B, 16'h0}, 16, 1'b1, rdy_n, rx);
			wait_done(k);
			if (i == 0)
				`CHK(k < 900, 1'b1);
			res = exp_word(vals[i]);
		end
		// Mode 1 never starts by itself
		cyc(CONV + 100);
		`CHK(converting, 1'b0);
		// Fresh once, then the same buffered result again
		for (int j = 0; j < 2; j++)
		begin
			host.xfer(32'h0, 16, 1'b1, rdy_n, rx);
			`CHK(rdy_n, j[0]);
			`CHK(rx[31:16], res);
		end
		// Every write-valid code, the valid one last; start sent as 1, bit 0 as 0
		cfg = CFG_RESET;
		for (int w = 0; w < 4; w++)
		begin
			wv = 2'(w + 2);
			host.xfer({2{8'hBB, 5'b01110, wv, 1'b0}}, 32, 1'b1, rdy_n, rx);
			if (wv == 2'h1)
				cfg = 16'h3B73;
			`CHK(rx[15:0], cfg);
			`CHK(settings, cfg);
			`CHK(rx[31:16], res);
		end
		`CHK(pout.weak_pullup_on, 1'b0);
		// Continuous mode runs while deselected
		raw <= 16'sd100;
		host.xfer({16'h048B, 16'h0}, 16, 1'b1, rdy_n, rx);
		cyc(3 * CONV);
		`CHK(converting, 1'b1);
		res = exp_word(100);
		// Broken transfer, recovered by time-out, then by deselect
		for (int m = 0; m < 2; m++)
		begin
			host.xfer(32'h0, 7, m[0], rdy_n, rx);
			if (m == 0)
				cyc(TOUT + 100);
			host.xfer(32'h0, 32, 1'b1, rdy_n, rx);
			`CHK(rx, {res, 16'h048B});
		end
		conclude();
	end

endmodule // testbench
